/* File: adcc_conv_model.sv */
// adcc_conv_model: behavioural converter answering conversion requests
`timescale 1ns/10ps
module adcc_conv_model (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        adc_conv,
   input  wire logic [11:0] code,
   input  wire logic [7:0]  dly,
   output logic             adc_done,
   output logic [11:0]      adc_raw
);
   logic [7:0] cnt_ff;
   // done comes dly+1 cycles into a request (dly must not be zero); the
   // data lines toggle outside that cycle so a stale code never looks valid
   always @(posedge clk_sys) begin
      adc_done <= 1'b0;
      adc_raw  <= ~adc_raw;
      cnt_ff   <= 8'h00;
      if (rst) begin
         adc_raw <= 12'h000;
      end else if (adc_conv && cnt_ff == dly) begin
         adc_done <= 1'b1;
         adc_raw  <= code;
      end else if (adc_conv) begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule

/* File: adcc_ctrl.sv */
// adcc_ctrl: adc sequencing, configuration and result registers
`timescale 1ns/10ps
module adcc_ctrl import adcc_pkg::*; #(
   parameter int PER_2K = PER_2K_CYC
) (
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire adcc_sfr_req_t sfr_req,
   output logic [7:0]         sfr_rdata,
   input  wire logic          pwrup,
   input  wire logic          conv_start,
   input  wire logic          adc_done,
   input  wire logic [11:0]   adc_raw,
   output logic               busy,
   output logic               adc_pwr,
   output logic               adc_sample,
   output logic               adc_conv,
   output logic [1:0]         adc_resol,
   output logic [1:0]         input_mode
);
   adcc_state_t state_ff, nxt_state;
   logic [7:0]  tim_ff, nxt_tim, fmt_ff, nxt_fmt;
   logic [7:0]  hi_ff, nxt_hi, lo_ff, nxt_lo, rd_ff, nxt_rd;
   logic        uf_ff, nxt_uf, of_ff, nxt_of;
   logic        busy_ff, nxt_busy, pwr_ff, nxt_pwr;
   logic        smp_ff, nxt_smp, cnv_ff, nxt_cnv;
   logic [10:0] cnt_ff, nxt_cnt;
   logic [15:0] per_ff, nxt_per;
   logic        forever_ff, nxt_forever;
   logic [11:0] mask;
   logic [15:0] aligned;
   logic [15:0] period;
   logic [10:0] acq_cyc;
   logic        cont;
   logic        load;

   assign cont = tim_ff[BIT_CONT];
   assign load = (state_ff == ST_CONV) && adc_done;

   // result shaping: converter code is masked and aligned but not recoded, so offset binary
   // coding of differential inputs reaches software as is
   always_comb begin
      mask = 12'(12'hfff >> (6 - 2*fmt_ff[7:6]));
      if (fmt_ff[BIT_RJUST]) begin
         aligned = {4'h0, adc_raw & mask};
      end else begin
         aligned = 16'({4'h0, adc_raw & mask} << (10 - 2*fmt_ff[7:6]));
      end
      case (tim_ff[1:0])
         2'b00:   acq_cyc = ACQ0_CYC;
         2'b01:   acq_cyc = ACQ1_CYC;
         2'b10:   acq_cyc = ACQ2_CYC;
         default: acq_cyc = ACQ3_CYC;
      endcase
      // reserved rate codes 1xx behave as their low two bits
      period = 16'(PER_2K >> tim_ff[3:2]);
   end

   // register file: result and flags are not writable
   always_comb begin
      nxt_tim = tim_ff;
      nxt_fmt = fmt_ff;
      nxt_hi  = hi_ff;
      nxt_lo  = lo_ff;
      nxt_uf  = uf_ff;
      nxt_of  = of_ff;
      nxt_rd  = rd_ff;
      if (sfr_req.wr) begin
         if (sfr_req.addr == ADDR_TIM_MODE) begin
            nxt_tim = sfr_req.wdata;
         end else if (sfr_req.addr == ADDR_FMT_STAT) begin
            nxt_fmt = {sfr_req.wdata[7:5], 5'h00};
         end
      end
      if (load) begin
         nxt_hi = aligned[15:8];
         nxt_lo = aligned[7:0];
         nxt_uf = ((adc_raw & mask) == 12'h000);
         nxt_of = ((adc_raw & mask) == mask);
      end
      if (sfr_req.rd) begin
         if (sfr_req.addr == ADDR_FMT_STAT) begin
            // range bit is the or of both flags, unused low bits zero
            nxt_rd = {fmt_ff[7:5], uf_ff, of_ff,
                      uf_ff | of_ff, 2'b00};
         end else if (sfr_req.addr == ADDR_TIM_MODE) begin
            nxt_rd = tim_ff;
         end else if (sfr_req.addr == ADDR_RES_HI) begin
            nxt_rd = hi_ff;
         end else if (sfr_req.addr == ADDR_RES_LO) begin
            nxt_rd = lo_ff;
         end else begin
            nxt_rd = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tim_ff <= RST_REG;
         fmt_ff <= RST_REG;
         hi_ff  <= RST_REG;
         lo_ff  <= RST_REG;
         rd_ff  <= RST_REG;
         uf_ff  <= 1'b0;
         of_ff  <= 1'b0;
      end else begin
         tim_ff <= nxt_tim;
         fmt_ff <= nxt_fmt;
         hi_ff  <= nxt_hi;
         lo_ff  <= nxt_lo;
         rd_ff  <= nxt_rd;
         uf_ff  <= nxt_uf;
         of_ff  <= nxt_of;
      end
   end

   // sequencer: wake, acquire, convert, then idle, hold or gap
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = (cnt_ff != 11'd0) ? cnt_ff - 11'd1 : cnt_ff;
      nxt_per     = (per_ff != 16'd0) ? per_ff - 16'd1 : per_ff;
      nxt_busy    = busy_ff;
      nxt_pwr     = pwr_ff;
      nxt_smp     = 1'b0;
      nxt_cnv     = 1'b0;
      nxt_forever = forever_ff;
      case (state_ff)
         ST_IDLE, ST_GAP, ST_HOLD: begin
            // cleared power-up or mode change ends a gap or hold
            if (!pwrup && state_ff != ST_IDLE) begin
               nxt_state = ST_IDLE;
               nxt_pwr   = 1'b0;
            end else if (pwrup && (cont ? (state_ff != ST_GAP ||
                         per_ff <= 16'd1) : conv_start)) begin
               nxt_state = ST_WAKE;
               nxt_busy  = 1'b1;
               nxt_pwr   = 1'b1;
               nxt_per   = period;
               // standby wakes faster than full power-down
               nxt_cnt   = (state_ff == ST_HOLD) ? WAKE_SB_CYC
                                                 : WAKE_PD_CYC;
            end else if (state_ff == ST_GAP && !cont) begin
               nxt_state = ST_IDLE;
            end else if (state_ff == ST_HOLD && !forever_ff &&
                         cnt_ff <= 11'd1) begin
               nxt_state = ST_IDLE;
               nxt_pwr   = 1'b0;
            end
         end
         ST_WAKE: begin
            if (cnt_ff <= 11'd1) begin
               nxt_state = ST_ACQ;
               nxt_smp   = 1'b1;
               nxt_cnt   = acq_cyc;
            end
         end
         ST_ACQ: begin
            nxt_smp = 1'b1;
            if (cnt_ff <= 11'd1) begin
               nxt_state = ST_CONV;
               nxt_smp   = 1'b0;
               nxt_cnv   = 1'b1;
            end
         end
         ST_CONV: begin
            nxt_cnv = 1'b1;
            if (adc_done) begin
               nxt_cnv  = 1'b0;
               nxt_busy = 1'b0;
               if (cont) begin
                  nxt_state = ST_GAP;
                  nxt_pwr   = 1'b0;
               end else begin
                  nxt_forever = 1'b0;
                  case (tim_ff[3:2])
                     2'b00: begin
                        nxt_state = ST_IDLE;
                        nxt_pwr   = 1'b0;
                     end
                     2'b01: begin
                        nxt_state = ST_HOLD;
                        nxt_cnt   = PD1_CYC;
                     end
                     2'b10: begin
                        nxt_state = ST_HOLD;
                        nxt_cnt   = PD2_CYC;
                     end
                     default: begin
                        nxt_state   = ST_HOLD;
                        nxt_forever = 1'b1;
                     end
                  endcase
               end
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_pwr   = 1'b0;
            nxt_busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff   <= ST_IDLE;
         cnt_ff     <= 11'd0;
         per_ff     <= 16'd0;
         busy_ff    <= 1'b0;
         pwr_ff     <= 1'b0;
         smp_ff     <= 1'b0;
         cnv_ff     <= 1'b0;
         forever_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         per_ff     <= nxt_per;
         busy_ff    <= nxt_busy;
         pwr_ff     <= nxt_pwr;
         smp_ff     <= nxt_smp;
         cnv_ff     <= nxt_cnv;
         forever_ff <= nxt_forever;
      end
   end

   assign sfr_rdata  = rd_ff;
   assign busy       = busy_ff;
   assign adc_pwr    = pwr_ff;
   assign adc_sample = smp_ff;
   assign adc_conv   = cnv_ff;
   assign adc_resol  = fmt_ff[7:6];
   assign input_mode = tim_ff[7:6];

   // checks
   property p_busy_drop;
      @(posedge clk_sys) disable iff (rst)
      load |=> !busy && hi_ff == $past(aligned[15:8]);
   endproperty
   a_busy_drop: assert property (p_busy_drop)
      else $error("busy or high byte wrong after load");
   property p_lo_load;
      @(posedge clk_sys) disable iff (rst)
      load |=> lo_ff == $past(aligned[7:0]);
   endproperty
   a_lo_load: assert property (p_lo_load)
      else $error("low byte wrong after load");
   property p_uflow;
      @(posedge clk_sys) disable iff (rst)
      load && (adc_raw & mask) == 12'h000 |=> uf_ff && !of_ff;
   endproperty
   a_uflow: assert property (p_uflow)
      else $error("underflow not flagged");
   property p_oflow;
      @(posedge clk_sys) disable iff (rst)
      load && (adc_raw & mask) == mask |=> of_ff;
   endproperty
   a_oflow: assert property (p_oflow)
      else $error("overflow not flagged");
   property p_range;
      @(posedge clk_sys) disable iff (rst)
      sfr_req.rd && sfr_req.addr == ADDR_FMT_STAT |=>
         sfr_rdata[BIT_RANGE] == (sfr_rdata[BIT_UFLOW] |
         sfr_rdata[BIT_OFLOW]) && sfr_rdata[1:0] == 2'b00;
   endproperty
   a_range: assert property (p_range)
      else $error("range bit or unused bits wrong");
   property p_ro_hi;
      @(posedge clk_sys) disable iff (rst)
      sfr_req.wr && sfr_req.addr == ADDR_RES_HI && !load |=>
         $stable(hi_ff);
   endproperty
   a_ro_hi: assert property (p_ro_hi)
      else $error("result byte took a write");
   property p_acq_len;
      @(posedge clk_sys) disable iff (rst)
      $rose(adc_sample) && tim_ff[1:0] == 2'b00 |->
         adc_sample[*8] ##22 adc_sample ##1 !adc_sample;
   endproperty
   a_acq_len: assert property (p_acq_len)
      else $error("acquisition window not 30 cycles");
   property p_no_pd;
      @(posedge clk_sys) disable iff (rst)
      load && !cont && tim_ff[3:2] == 2'b00 |=> !adc_pwr;
   endproperty
   a_no_pd: assert property (p_no_pd)
      else $error("converter still powered with zero delay");
   property p_gap_off;
      @(posedge clk_sys) disable iff (rst)
      load && cont |=> !adc_pwr && state_ff == ST_GAP;
   endproperty
   a_gap_off: assert property (p_gap_off)
      else $error("converter not powered down between samples");
endmodule

/* File: adcc_pkg.sv */
// adcc_pkg: constants and types of the adc conversion control block
// Behaviour
// - The input mode field picks single ended (00), differential against analog_input_2 (01) or analog_input_6 (10); 11 is unused.
// - Bit 5 of the timing and mode register picks one conversion per start (0) or continuous conversion (1).
// - In continuous mode the rate field gives 2, 4, 8 or 16 ksps for 000 to 011; 1XX is reserved.
// - In single step mode the rate field gives a power-down delay of none, 6 us, 24 us, or stay powered until power-up is cleared.
// - The acquisition field gives a sampling window of 0.75, 3, 12 or 36 us.
// - The justification bit places the result left aligned when 0 and right aligned when 1.
// - Resolution codes 00 to 11 give 6, 8, 10 or 12 bit results, left from high bit 7 or right to low bit 0, unused bits zero.
// - The underflow flag in bit 4 of the format and status register is set when the result is all zeroes.
// - The overflow flag in bit 3 of the format and status register is set when the result is all ones.
// - Bit 2 of the format and status register always reads the OR of overflow and underflow.
// - The result register at 0xd4 returns the high byte of the aligned result.
// - The result register at 0xd5 returns the low byte of the aligned result.
// - Busy stays high while a conversion runs and drops when the result bytes are loaded.
// - Continuous mode starts conversions at the set rate and powers the converter down between them.
// - Differential results use offset binary coding, passed through from the converter unchanged.
package adcc_pkg;
   localparam logic [7:0] ADDR_FMT_STAT = 8'hd1;
   localparam logic [7:0] ADDR_TIM_MODE = 8'hd2;
   localparam logic [7:0] ADDR_RES_HI   = 8'hd4;
   localparam logic [7:0] ADDR_RES_LO   = 8'hd5;
   localparam logic [7:0] RST_REG       = 8'h00;
   localparam int BIT_CONT  = 5;
   localparam int BIT_RJUST = 5;
   localparam int BIT_UFLOW = 4;
   localparam int BIT_OFLOW = 3;
   localparam int BIT_RANGE = 2;
   localparam int CLK_NS    = 25;
   // times in ns as printed, cycle counts rounded up (least times)
   localparam int T_WAKE_PD_NS = 15000;
   localparam int T_WAKE_SB_NS = 600;
   localparam int T_ACQ0_NS = 750;
   localparam int T_ACQ1_NS = 3000;
   localparam int T_ACQ2_NS = 12000;
   localparam int T_ACQ3_NS = 36000;
   localparam int T_PD1_NS  = 6000;
   localparam int T_PD2_NS  = 24000;
   localparam int T_PER_2K_NS = 500000;
   localparam logic [10:0] WAKE_PD_CYC = 11'((T_WAKE_PD_NS+CLK_NS-1)/CLK_NS);
   localparam logic [10:0] WAKE_SB_CYC = 11'((T_WAKE_SB_NS+CLK_NS-1)/CLK_NS);
   localparam logic [10:0] ACQ0_CYC = 11'((T_ACQ0_NS+CLK_NS-1)/CLK_NS);
   localparam logic [10:0] ACQ1_CYC = 11'((T_ACQ1_NS+CLK_NS-1)/CLK_NS);
   localparam logic [10:0] ACQ2_CYC = 11'((T_ACQ2_NS+CLK_NS-1)/CLK_NS);
   localparam logic [10:0] ACQ3_CYC = 11'((T_ACQ3_NS+CLK_NS-1)/CLK_NS);
   localparam logic [10:0] PD1_CYC  = 11'((T_PD1_NS+CLK_NS-1)/CLK_NS);
   localparam logic [10:0] PD2_CYC  = 11'((T_PD2_NS+CLK_NS-1)/CLK_NS);
   localparam int PER_2K_CYC = T_PER_2K_NS/CLK_NS;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAKE = 3'b001,
      ST_ACQ  = 3'b010,
      ST_CONV = 3'b011,
      ST_HOLD = 3'b100,
      ST_GAP  = 3'b101
   } adcc_state_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } adcc_sfr_req_t;
endpackage

/* File: tb_adc_conversion_control.sv */
// tb_adc_conversion_control: self-checking bench for the adc control
`timescale 1ns/10ps
module tb_adc_conversion_control import adcc_pkg::*;;
   localparam int PER = 6400;
   logic          clk_sys, rst, pwrup, conv_start, adc_done;
   logic          busy, adc_pwr, adc_sample, adc_conv;
   logic [7:0]    sfr_rdata, dly;
   logic [11:0]   adc_raw, code;
   logic [1:0]    adc_resol, input_mode;
   adcc_sfr_req_t req;
   int            error_cnt, total_checks;

   // short period keeps continuous runs brief but above one conversion
   adcc_ctrl #(.PER_2K(PER)) dut_u (.clk_sys(clk_sys), .rst(rst),
      .sfr_req(req), .sfr_rdata(sfr_rdata), .pwrup(pwrup),
      .conv_start(conv_start), .adc_done(adc_done), .adc_raw(adc_raw),
      .busy(busy), .adc_pwr(adc_pwr), .adc_sample(adc_sample),
      .adc_conv(adc_conv), .adc_resol(adc_resol), .input_mode(input_mode));
   adcc_conv_model conv_u (.clk_sys(clk_sys), .rst(rst), .adc_conv(adc_conv),
      .code(code), .dly(dly), .adc_done(adc_done), .adc_raw(adc_raw));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic test_done;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask

   // read data is registered, so it is looked at one cycle after rd
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1 chk({8'h00, sfr_rdata}, {8'h00, e});
   endtask

   // wait for busy to reach v, tallying sample cycles and power-off seen
   task automatic wt(input logic v, input int lim, output int n,
                     output int acq, output logic off);
      n   = 0;
      acq = 0;
      off = 1'b0;
      #1;
      while (busy !== v && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
         acq += int'(adc_sample);
         if (adc_pwr === 1'b0) off = 1'b1;
      end
      if (busy !== v) chk({15'h0, busy}, {15'h0, v});
   endtask

   task automatic conv(input logic [11:0] c, output int acq);
      int   n;
      logic o;
      @(posedge clk_sys);
      code       <= c;
      conv_start <= 1'b1;
      @(posedge clk_sys);
      conv_start <= 1'b0;
      #1 chk({15'h0, busy}, 16'h0001);
      wt(1'b0, 4000, n, acq, o);
   endtask

   task automatic t_reset;
      rc(ADDR_FMT_STAT, 8'h00);
      rc(ADDR_TIM_MODE, 8'h00);
      rc(ADDR_RES_HI, 8'h00);
      rc(ADDR_RES_LO, 8'h00);
      wr(8'hd0, 8'hff);
      rc(8'hd0, 8'h00);
      wr(ADDR_TIM_MODE, 8'hdf);
      rc(ADDR_TIM_MODE, 8'hdf);
      wr(ADDR_TIM_MODE, 8'h00);
   endtask

   // every resolution and alignment; flags written high must not stick
   task automatic t_format;
      logic [11:0] m, c;
      logic [15:0] e;
      logic [1:0]  r;
      logic        j, uf, of;
      int          a;
      int          acq_tab [4] = '{30, 120, 480, 1440};
      for (int i = 0; i < 8; i++) begin
         r  = 2'(i % 4);
         j  = (i >= 4);
         m  = 12'hfff >> (6 - 2 * r);
         c  = (i % 3 == 0) ? m : (i % 3 == 1) ? 12'h000 : (12'hb6d & m);
         uf = (c == 12'h000);
         of = (c == m);
         e  = j ? {4'h0, c} : 16'({4'h0, c} << (10 - 2 * r));
         wr(ADDR_FMT_STAT, {r, j, 5'h1f});
         wr(ADDR_TIM_MODE, {6'h00, r});
         conv(c | (~m & 12'ha5a), a);
         chk({15'h0, adc_pwr}, 16'h0000);
         chk({15'h0, adc_conv}, 16'h0000);
         chk(16'(a), 16'(acq_tab[r]));
         chk({14'h0, adc_resol}, {14'h0, r});
         wr(ADDR_RES_HI, 8'hff);
         rc(ADDR_RES_HI, e[15:8]);
         rc(ADDR_RES_LO, e[7:0]);
         rc(ADDR_FMT_STAT, {r, j, uf, of, uf | of, 2'b00});
      end
   endtask

   // power-down delay codes, each with one input mode and a slow converter
   task automatic t_delay;
      int a, n, e;
      logic o;
      int dl [3] = '{240, 960, 1200};
      @(posedge clk_sys);
      dly <= 8'h50;
      wr(ADDR_FMT_STAT, 8'he0);
      for (int k = 1; k < 4; k++) begin
         wr(ADDR_TIM_MODE, {2'(k - 1), 1'b0, 3'(k), 2'b00});
         conv(12'h800, a);
         chk({14'h0, input_mode}, 16'(k - 1));
         rc(ADDR_RES_HI, 8'h08);
         rc(ADDR_RES_LO, 8'h00);
         repeat (dl[k-1] - 10) @(posedge clk_sys);
         #1 chk({15'h0, adc_pwr}, 16'h0001);
         // a start while held powered wakes from standby, the short way
         if (k == 3) begin
            @(posedge clk_sys);
            conv_start <= 1'b1;
            @(posedge clk_sys);
            conv_start <= 1'b0;
            e = WAKE_SB_CYC + ACQ0_CYC + dly + 2;
            wt(1'b0, 4000, n, a, o);
            chk(16'(n), 16'(e));
         end
         @(posedge clk_sys);
         if (k == 3) pwrup <= 1'b0;
         repeat (20) @(posedge clk_sys);
         #1 chk({15'h0, adc_pwr}, 16'h0000);
         @(posedge clk_sys);
         pwrup <= 1'b1;
      end
   endtask

   // the new rate rules from the start after the write, so skip one rise
   task automatic t_cont;
      int   n1, n2, a;
      logic o;
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_TIM_MODE, {3'b001, 3'(k), 2'b00});
         wt(1'b0, 4000, n1, a, o);
         wt(1'b1, PER + 100, n1, a, o);
         wt(1'b0, 4000, n1, a, o);
         wt(1'b1, PER + 100, n2, a, o);
         chk(16'(n1 + n2), 16'(PER >> k));
         chk({15'h0, o}, 16'h0001);
      end
      @(posedge clk_sys);
      pwrup <= 1'b0;
      wt(1'b0, 4000, n1, a, o);
      wr(ADDR_TIM_MODE, 8'h00);
   endtask

   // a hang is cut well past the expected run of about 40k cycles
   initial begin
      #(80000 * 25);
      error_cnt++;
      test_done;
   end

   initial begin
      rst          = 1'b1;
      pwrup        = 1'b0;
      conv_start   = 1'b0;
      req          = '0;
      code         = 12'h000;
      dly          = 8'h04;
      error_cnt    = 0;
      total_checks = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      @(posedge clk_sys);
      pwrup <= 1'b1;
      t_format;
      t_delay;
      t_cont;
      test_done;
   end
endmodule
